// ==== usm_pkg.sv ====
package usm_pkg;
   // ---------------------------------------------------------------
   // register map (word index on the plain port)
   // ---------------------------------------------------------------
   localparam logic [3:0] ADDR_TX_BUFFER = 4'h0;
   localparam logic [3:0] ADDR_RX_BUFFER = 4'h1;
   localparam logic [3:0] ADDR_BAUD_DIVISOR = 4'h2;
   localparam logic [3:0] ADDR_CHANNEL_MODE = 4'h3;
   localparam logic [3:0] ADDR_CHANNEL_CTRL0 = 4'h4;
   localparam logic [3:0] ADDR_CHANNEL_CTRL1 = 4'h5;
   localparam logic [3:0] ADDR_SPECIAL_MODE = 4'h6;
   localparam logic [3:0] ADDR_STATUS = 4'h7;

   // ---------------------------------------------------------------
   // channel_mode_reg fields
   // ---------------------------------------------------------------
   localparam int MODE_SEL_LSB = 0;
   localparam int CLK_SRC_BIT = 3;
   localparam int POL_INV_BIT = 7;
   // channel_ctrl0_reg fields
   localparam int PRESCALE_LSB = 0;
   localparam int TX_EMPTY_BIT = 3;
   localparam int OUT_TYPE_BIT = 5;
   localparam int INV_FMT_BIT = 6;
   // channel_ctrl1_reg fields
   localparam int TX_EN_BIT = 0;
   localparam int TX_BUF_EMPTY_BIT = 1;
   localparam int RX_EN_BIT = 2;
   localparam int RX_DONE_BIT = 3;
   localparam int TX_IRQ_SRC_BIT = 4;
   localparam int PAR_SIG_EN_BIT = 7;
   // special_mode_reg fields
   localparam int COLL_SAMPLE_BIT = 4;
   localparam int AUTOCLEAR_BIT = 5;
   localparam int START_COND_BIT = 6;
   // rx_buffer_reg / status fields
   localparam int OVERRUN_BIT = 12;
   localparam int FRAMING_BIT = 13;
   localparam int PARITY_BIT = 14;
   localparam int ERR_SUM_BIT = 15;
   localparam int COLLISION_BIT = 0;

   // ---------------------------------------------------------------
   // modes and timing
   // ---------------------------------------------------------------
   localparam logic [2:0] MODE_UART = 3'h5;
   localparam logic [2:0] MODE_SHARED_BUS = 3'h6;
   localparam logic [2:0] MODE_SMART_CARD = 3'h7;
   localparam logic [3:0] OVERSAMPLE_LAST = 4'hf;
   localparam logic [3:0] SAMPLE_MID = 4'h7;
   localparam logic [3:0] SAMPLE_RISE = 4'hf;
   localparam logic [3:0] BITS_PER_CHAR = 4'ha;
   localparam logic [3:0] PARITY_SLOT = 4'h9;
   localparam logic [3:0] STOP_SLOT = 4'ha;
   localparam logic [3:0] PAR_SIG_SLOTS = 4'h1;
   localparam logic [7:0] RESET_CTRL1 = 8'h02;
endpackage : usm_pkg

// ==== usm_baud_gen.sv ====
`timescale 1ns/1ps
// one enable pulse per sixteenth of a bit
module usm_baud_gen
(
   input wire logic clock,
   input wire logic rst_n,
   input wire logic use_external,
   input wire logic ext_clock_pin,
   input wire logic [1:0] prescale_sel,
   input wire logic [7:0] divisor,
   output logic tick
);
   logic [4:0] pre_reg;
   logic [7:0] cnt_reg;
   logic ext_q_reg;
   logic ext_rise;
   logic src_en;
   logic [3:0] pre_hit;

   // ---------------------------------------------------------------
   // four prescaler taps: /1 /2 /8 /32
   // ---------------------------------------------------------------
   assign pre_hit[0] = 1'b1;
   assign pre_hit[1] = pre_reg[0];
   assign pre_hit[2] = &pre_reg[2:0];
   assign pre_hit[3] = &pre_reg;
   // ext pin is taken as synchronous; edge detect only
   assign ext_rise = ext_clock_pin & ~ext_q_reg;
   assign src_en = use_external ? ext_rise : pre_hit[prescale_sel];

   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         pre_reg <= 5'h00;
         cnt_reg <= 8'h00;
         ext_q_reg <= 1'b0;
         tick <= 1'b0;
      end
      else
      begin
         pre_reg <= pre_reg + 5'h01;
         ext_q_reg <= ext_clock_pin;
         tick <= 1'b0;
         if (src_en)
         begin
            // divide by n+1
            if (cnt_reg >= divisor)
            begin
               cnt_reg <= 8'h00;
               tick <= 1'b1;
            end
            else
               cnt_reg <= cnt_reg + 8'h01;
         end
      end
   end
endmodule : usm_baud_gen

// ==== usm_rx_shift.sv ====
`timescale 1ns/1ps
// receive shifter: start detect, 16x sampling, frame collect
module usm_rx_shift
(
   input wire logic clock,
   input wire logic rst_n,
   input wire logic tick,
   input wire logic enable,
   input wire logic rx_level,
   output logic busy,
   output logic near_end,
   output logic done,
   output logic [9:0] frame
);
   logic [3:0] phase_reg;
   logic [3:0] slot_reg;
   logic mid;

   assign mid = tick && (phase_reg == usm_pkg::SAMPLE_MID);

   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         busy <= 1'b0;
         phase_reg <= 4'h0;
         slot_reg <= 4'h0;
         frame <= 10'h000;
         done <= 1'b0;
         near_end <= 1'b0;
      end
      else
      begin
         done <= 1'b0;
         near_end <= 1'b0;
         if (!busy)
         begin
            phase_reg <= 4'h0;
            slot_reg <= 4'h0;
            if (enable && tick && !rx_level)
               busy <= 1'b1;
         end
         else if (tick)
         begin
            phase_reg <= phase_reg + 4'h1;
            if (mid)
            begin
               // a start bit that vanished at mid-bit is a glitch
               if (slot_reg == 4'h0 && rx_level)
                  busy <= 1'b0;
               if (slot_reg != 4'h0)
                  frame <= {rx_level, frame[9:1]};
               if (slot_reg == usm_pkg::PARITY_SLOT)
                  near_end <= 1'b1;
               if (slot_reg == usm_pkg::STOP_SLOT)
               begin
                  busy <= 1'b0;
                  done <= 1'b1;
               end
               slot_reg <= slot_reg + 4'h1;
            end
         end
      end
   end
endmodule : usm_rx_shift

// ==== usm_channel.sv ====
`timescale 1ns/1ps
// Operation
// [R1] shared-bus mode sends one full UART character per bus bit
// [R2] collision flagged when driven tx level differs from sampled rx level
// [R3] control bit picks the collision compare sampling point
// [R4] auto-clear option drops tx enable on collision
// [R5] control bit picks the condition that lets queued transmit start
// [R6] polarity bit inverts tx output and rx input in shared-bus mode
// [R7] tx pin is open-drain only; output type bit absent
// [R8] software writes zero to unassigned bits
// [R9] smart-card mode pulls tx low on rx parity error; two formats
// [R10] internal rate is prescaled source over 16 times divisor plus one
// [R11] external rate is clock pin over 16 times divisor plus one
// [R12] transmit starts only when enabled and buffer holds data
// [R13] receive starts only when enabled and start bit seen
// [R14] completion-source tx interrupt fires when shifter finished
// [R15] rx interrupt fires when character moves into rx buffer
// [R16] overrun flagged when next char reaches bit before stop unread
// [R17] framing error when stop bit missing
// [R18] parity error during reception emits parity signal on tx pin
// [R19] software checks rx pin at tx interrupt for returned parity error
// [R20] error-sum flag set when any error flag set
// [R21] on overrun rx data undefined and no rx interrupt
// [R22] reading rx buffer during parity signal clears flag, releases tx
// [R23] direct format: lsb first, true data, even parity
// [R24] inverse format: inverted data, msb first, odd parity
// [R25] 3-bit mode field selects uart, shared-bus or smart-card
module usm_channel
(
   input wire logic clock,
   input wire logic rst_n,
   input wire logic [3:0] addr,
   input wire logic [15:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [15:0] rdata,
   input wire logic serial_rx_pin,
   input wire logic serial_ext_clock_pin,
   output logic serial_tx_out,
   output logic serial_tx_oe_n,
   output logic tx_irq,
   output logic rx_irq,
   output logic collision_irq
);
   typedef enum logic [2:0]
   {
      USM_IDLE = 3'b001,
      USM_SEND = 3'b010,
      USM_PSIG = 3'b100
   } usm_tx_state_t;

   usm_tx_state_t state_reg;
   logic [7:0] tx_buffer_reg;
   logic [7:0] baud_divisor_reg;
   logic [7:0] channel_mode_reg;
   logic [7:0] channel_ctrl0_reg;
   logic [7:0] channel_ctrl1_reg;
   logic [7:0] special_mode_reg;
   logic [15:0] rx_buffer_reg;
   logic [9:0] tx_shift_reg;
   logic [3:0] tx_phase_reg;
   logic [3:0] tx_slot_reg;
   logic collision_flag_reg;
   logic rx_unread_reg;
   logic rx_idle_q_reg;
   logic tx_line_reg;
   logic tick;
   logic rx_busy;
   logic rx_near_end;
   logic rx_done;
   logic [9:0] rx_frame;

   // ---------------------------------------------------------------
   // decode
   // ---------------------------------------------------------------
   wire [2:0] mode_select_field = channel_mode_reg[usm_pkg::MODE_SEL_LSB +: 3];
   wire shared_bus_mode = mode_select_field == usm_pkg::MODE_SHARED_BUS; // [R25]
   wire smart_card_mode = mode_select_field == usm_pkg::MODE_SMART_CARD; // [R25]
   wire uart_mode = mode_select_field == usm_pkg::MODE_UART; // [R25]
   wire active = shared_bus_mode || smart_card_mode || uart_mode;
   wire clock_source_select = channel_mode_reg[usm_pkg::CLK_SRC_BIT];
   wire line_polarity_invert = channel_mode_reg[usm_pkg::POL_INV_BIT] && shared_bus_mode; // [R6]
   wire tx_enable_bit = channel_ctrl1_reg[usm_pkg::TX_EN_BIT];
   wire tx_buffer_empty_flag = channel_ctrl1_reg[usm_pkg::TX_BUF_EMPTY_BIT];
   wire rx_enable_bit = channel_ctrl1_reg[usm_pkg::RX_EN_BIT];
   wire tx_irq_source_select = channel_ctrl1_reg[usm_pkg::TX_IRQ_SRC_BIT];
   wire parity_signal_enable = channel_ctrl1_reg[usm_pkg::PAR_SIG_EN_BIT];
   wire collision_sample_select = special_mode_reg[usm_pkg::COLL_SAMPLE_BIT];
   wire tx_enable_autoclear = special_mode_reg[usm_pkg::AUTOCLEAR_BIT];
   wire tx_start_condition_select = special_mode_reg[usm_pkg::START_COND_BIT];
   wire inverse_fmt = smart_card_mode && channel_ctrl0_reg[usm_pkg::INV_FMT_BIT];
   wire rx_level = serial_rx_pin ^ line_polarity_invert; // [R6]

   wire wr_tx = wr && addr == usm_pkg::ADDR_TX_BUFFER;
   wire rd_rx = rd && addr == usm_pkg::ADDR_RX_BUFFER;
   wire wr_c1 = wr && addr == usm_pkg::ADDR_CHANNEL_CTRL1;

   // ---------------------------------------------------------------
   // transmit framing
   // ---------------------------------------------------------------
   // direct: lsb first, even parity; inverse: inverted, msb first, odd
   wire [7:0] tx_rev = {<<{tx_buffer_reg}};
   wire [7:0] tx_data = inverse_fmt ? ~tx_rev : tx_buffer_reg; // [R23] [R24]
   wire tx_par = smart_card_mode ? (^tx_data) ^ inverse_fmt : 1'b1; // [R23] [R24]
   // shared-bus: one bus bit = one whole character (start, 8 data, two stop)
   wire [9:0] tx_frame = smart_card_mode ? {1'b1, tx_par, tx_data} : {1'b1, 1'b1, tx_data}; // [R1]

   // start condition: immediately, or wait for idle bus (rx idle, no char)
   wire bus_free = !rx_busy && rx_idle_q_reg;
   wire start_ok = tx_start_condition_select ? bus_free : 1'b1; // [R5]
   wire tx_go = active && tx_enable_bit && !tx_buffer_empty_flag && start_ok; // [R12]

   wire tx_bit_end = tick && tx_phase_reg == usm_pkg::OVERSAMPLE_LAST;
   wire tx_char_done = tx_bit_end && tx_slot_reg == usm_pkg::BITS_PER_CHAR;

   // collision compare point: mid-bit or end of bit
   wire [3:0] coll_pt = collision_sample_select ? usm_pkg::SAMPLE_RISE : usm_pkg::SAMPLE_MID; // [R3]
   wire coll_now = shared_bus_mode && state_reg == USM_SEND && tick
      && tx_phase_reg == coll_pt && (tx_line_reg != rx_level); // [R2]

   // ---------------------------------------------------------------
   // receive decode
   // ---------------------------------------------------------------
   wire [7:0] rx_raw = rx_frame[7:0];
   wire [7:0] rx_rev = {<<{rx_raw}};
   wire [7:0] rx_data = inverse_fmt ? ~rx_rev : rx_raw; // [R23] [R24]
   wire rx_par_err = smart_card_mode && (^rx_frame[8:0]) != inverse_fmt; // [R23] [R24]
   wire rx_frm_err = !rx_frame[9]; // [R17]
   wire rx_overrun = rx_unread_reg; // [R16]
   wire psig_start = rx_done && rx_par_err && parity_signal_enable && !rx_overrun; // [R18]
   wire tx_load = state_reg == USM_IDLE && !psig_start && tx_go && tick; // [R12]
   // own error pulse, and its last registered cycle, is no start bit
   wire rx_hold = state_reg == USM_PSIG
      || (state_reg == USM_IDLE && serial_tx_oe_n == line_polarity_invert);

   // ---------------------------------------------------------------
   // sub-blocks
   // ---------------------------------------------------------------
   usm_baud_gen u_baud
   (
      .clock(clock),
      .rst_n(rst_n),
      .use_external(clock_source_select), // [R11]
      .ext_clock_pin(serial_ext_clock_pin),
      .prescale_sel(channel_ctrl0_reg[usm_pkg::PRESCALE_LSB +: 2]), // [R10]
      .divisor(baud_divisor_reg),
      .tick(tick)
   );

   usm_rx_shift u_rx
   (
      .clock(clock),
      .rst_n(rst_n),
      .tick(tick),
      .enable(active && rx_enable_bit && !rx_hold), // [R13]
      .rx_level(rx_level),
      .busy(rx_busy),
      .near_end(rx_near_end),
      .done(rx_done),
      .frame(rx_frame)
   );

   // ---------------------------------------------------------------
   // registers
   // ---------------------------------------------------------------
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         tx_buffer_reg <= 8'h00;
         baud_divisor_reg <= 8'h00;
         channel_mode_reg <= 8'h00;
         channel_ctrl0_reg <= 8'h00;
         special_mode_reg <= 8'h00;
      end
      else if (wr)
      begin
         // unassigned bits are stored as written; software keeps them zero
         unique case (addr)
            usm_pkg::ADDR_TX_BUFFER: tx_buffer_reg <= wdata[7:0];
            usm_pkg::ADDR_BAUD_DIVISOR: baud_divisor_reg <= wdata[7:0];
            usm_pkg::ADDR_CHANNEL_MODE: channel_mode_reg <= wdata[7:0];
            // output type bit does not exist; it reads zero
            usm_pkg::ADDR_CHANNEL_CTRL0: channel_ctrl0_reg <= wdata[7:0] & 8'hd7; // [R7] [R8]
            usm_pkg::ADDR_SPECIAL_MODE: special_mode_reg <= wdata[7:0];
            default: ;
         endcase
      end
   end

   // ctrl1: tx enable may be auto-cleared; buffer-empty flag owned by hw
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
         channel_ctrl1_reg <= usm_pkg::RESET_CTRL1;
      else
      begin
         if (wr_c1)
         begin
            channel_ctrl1_reg[usm_pkg::TX_EN_BIT] <= wdata[usm_pkg::TX_EN_BIT];
            channel_ctrl1_reg[usm_pkg::RX_EN_BIT] <= wdata[usm_pkg::RX_EN_BIT];
            channel_ctrl1_reg[usm_pkg::TX_IRQ_SRC_BIT] <= wdata[usm_pkg::TX_IRQ_SRC_BIT];
            channel_ctrl1_reg[usm_pkg::PAR_SIG_EN_BIT] <= wdata[usm_pkg::PAR_SIG_EN_BIT];
         end
         if (coll_now && tx_enable_autoclear)
            channel_ctrl1_reg[usm_pkg::TX_EN_BIT] <= 1'b0; // [R4]
         // load into shifter empties the buffer; a write fills it
         if (wr_tx)
            channel_ctrl1_reg[usm_pkg::TX_BUF_EMPTY_BIT] <= 1'b0;
         else if (tx_load)
            channel_ctrl1_reg[usm_pkg::TX_BUF_EMPTY_BIT] <= 1'b1;
         if (rx_done && !rx_overrun)
            channel_ctrl1_reg[usm_pkg::RX_DONE_BIT] <= 1'b1;
         else if (rd_rx)
            channel_ctrl1_reg[usm_pkg::RX_DONE_BIT] <= 1'b0;
         channel_ctrl1_reg[6:5] <= 2'h0;
      end
   end

   // ---------------------------------------------------------------
   // transmitter and parity-signal driver
   // ---------------------------------------------------------------
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state_reg <= USM_IDLE;
         tx_shift_reg <= 10'h3ff;
         tx_phase_reg <= 4'h0;
         tx_slot_reg <= 4'h0;
         tx_line_reg <= 1'b1;
      end
      else
      begin
         unique case (state_reg)
            USM_IDLE:
            begin
               tx_line_reg <= 1'b1;
               if (psig_start)
                  state_reg <= USM_PSIG; // [R9] [R18]
               else if (tx_go && tick)
               begin
                  tx_shift_reg <= tx_frame;
                  tx_line_reg <= 1'b0;
                  tx_phase_reg <= 4'h0;
                  tx_slot_reg <= 4'h0;
                  state_reg <= USM_SEND;
               end
            end
            USM_SEND:
            begin
               if (tick)
                  tx_phase_reg <= tx_phase_reg + 4'h1;
               if (tx_bit_end)
               begin
                  tx_slot_reg <= tx_slot_reg + 4'h1;
                  tx_line_reg <= tx_shift_reg[0];
                  tx_shift_reg <= {1'b1, tx_shift_reg[9:1]};
               end
               if (tx_char_done)
               begin
                  tx_line_reg <= 1'b1;
                  state_reg <= USM_IDLE;
               end
            end
            USM_PSIG:
            begin
               // held low until the rx buffer is read
               tx_line_reg <= 1'b0;
               if (rd_rx)
               begin
                  tx_line_reg <= 1'b1; // [R22]
                  state_reg <= USM_IDLE;
               end
            end
         endcase
      end
   end

   // ---------------------------------------------------------------
   // receive buffer and error flags
   // ---------------------------------------------------------------
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rx_buffer_reg <= 16'h0000;
         rx_unread_reg <= 1'b0;
         rx_idle_q_reg <= 1'b1;
         collision_flag_reg <= 1'b0;
      end
      else
      begin
         rx_idle_q_reg <= rx_level;
         if (rd_rx)
         begin
            rx_unread_reg <= 1'b0;
            rx_buffer_reg[usm_pkg::PARITY_BIT] <= 1'b0; // [R22]
         end
         if (rx_near_end && rx_unread_reg)
            rx_buffer_reg[usm_pkg::OVERRUN_BIT] <= 1'b1; // [R16]
         if (rx_done)
         begin
            // on overrun data bits keep stale contents (undefined)
            if (!rx_overrun)
               rx_buffer_reg[7:0] <= rx_data; // [R21]
            rx_unread_reg <= 1'b1;
            rx_buffer_reg[usm_pkg::FRAMING_BIT] <= rx_frm_err; // [R17]
            rx_buffer_reg[usm_pkg::PARITY_BIT] <= rx_par_err;
            rx_buffer_reg[usm_pkg::OVERRUN_BIT] <= rx_overrun;
         end
         // set wins over the read clear
         if (coll_now)
            collision_flag_reg <= 1'b1;
         else if (rd && addr == usm_pkg::ADDR_STATUS)
            collision_flag_reg <= 1'b0;
      end
   end

   wire err_sum = rx_buffer_reg[usm_pkg::OVERRUN_BIT] | rx_buffer_reg[usm_pkg::FRAMING_BIT]
      | rx_buffer_reg[usm_pkg::PARITY_BIT]; // [R20]

   // ---------------------------------------------------------------
   // read mux and outputs
   // ---------------------------------------------------------------
   wire tx_empty = state_reg != USM_SEND;
   logic [15:0] rd_mux;
   always_comb
   begin
      unique case (addr)
         usm_pkg::ADDR_TX_BUFFER: rd_mux = {8'h00, tx_buffer_reg};
         usm_pkg::ADDR_RX_BUFFER: rd_mux = {err_sum, rx_buffer_reg[14:0]};
         usm_pkg::ADDR_BAUD_DIVISOR: rd_mux = {8'h00, baud_divisor_reg};
         usm_pkg::ADDR_CHANNEL_MODE: rd_mux = {8'h00, channel_mode_reg};
         usm_pkg::ADDR_CHANNEL_CTRL0: rd_mux = {8'h00, channel_ctrl0_reg[7:4], tx_empty,
            channel_ctrl0_reg[2:0]};
         usm_pkg::ADDR_CHANNEL_CTRL1: rd_mux = {8'h00, channel_ctrl1_reg};
         usm_pkg::ADDR_SPECIAL_MODE: rd_mux = {8'h00, special_mode_reg};
         usm_pkg::ADDR_STATUS: rd_mux = {15'h0000, collision_flag_reg};
         default: rd_mux = 16'h0000;
      endcase
   end

   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rdata <= 16'h0000;
         serial_tx_out <= 1'b0;
         serial_tx_oe_n <= 1'b1;
         tx_irq <= 1'b0;
         rx_irq <= 1'b0;
         collision_irq <= 1'b0;
      end
      else
      begin
         rdata <= rd ? rd_mux : 16'h0000;
         // open drain only: enable low drives the pin low
         serial_tx_out <= 1'b0; // [R7]
         serial_tx_oe_n <= tx_line_reg ^ line_polarity_invert ? 1'b1 : 1'b0; // [R7] [R6]
         // completion source: shifter done; else buffer handed over
         tx_irq <= tx_irq_source_select ? tx_char_done
            : tx_load; // [R14] [R19]
         rx_irq <= rx_done && !rx_overrun; // [R15] [R21]
         collision_irq <= coll_now; // [R2]
      end
   end
endmodule : usm_channel

// ==== usm_channel_assertions.sv ====
`timescale 1ns/1ps
module usm_channel_assertions
(
   input wire logic clock,
   input wire logic rst_n,
   input wire logic serial_rx_pin,
   input wire logic serial_tx_out,
   input wire logic serial_tx_oe_n,
   input wire logic tx_irq,
   input wire logic rx_irq,
   input wire logic collision_irq
);
   default clocking @(posedge clock); endclocking
   default disable iff (!rst_n);
   logic [2:0] mis;
   logic low_seen;
   // raw pins: a wider mismatch window only loosens the check
   always_ff @(posedge clock or negedge rst_n)
      if (!rst_n)
         mis <= 3'h7;
      else
         mis <= (serial_tx_oe_n != serial_rx_pin) ? 3'h0 : mis + {2'h0, mis != 3'h7};
   always_ff @(posedge clock or negedge rst_n)
      if (!rst_n)
         low_seen <= 1'b0;
      else
         low_seen <= (low_seen | !serial_rx_pin) & !rx_irq;
   property p_od; serial_tx_out == 1'b0; endproperty
   a_od: assert property (p_od) else $error("tx data not zero");
   property p_txp; tx_irq |=> !tx_irq; endproperty
   a_txp: assert property (p_txp) else $error("tx irq too long");
   property p_txend; tx_irq |-> serial_tx_oe_n && $past(serial_tx_oe_n, 8); endproperty
   a_txend: assert property (p_txend) else $error("tx irq before stop");
   property p_rxp; rx_irq |=> !rx_irq; endproperty
   a_rxp: assert property (p_rxp) else $error("rx irq too long");
   property p_rxst; rx_irq |-> low_seen; endproperty
   a_rxst: assert property (p_rxst) else $error("rx irq without start");
   property p_bit; $fell(serial_tx_oe_n) |-> !serial_tx_oe_n [*8]; endproperty
   a_bit: assert property (p_bit) else $error("low level too short");
   property p_colc; collision_irq |-> mis != 3'h7; endproperty
   a_colc: assert property (p_colc) else $error("collision without cause");
   property p_colp; collision_irq |=> !collision_irq; endproperty
   a_colp: assert property (p_colp) else $error("collision irq too long");
endmodule : usm_channel_assertions
bind usm_channel usm_channel_assertions i_usm_channel_assertions (.clock, .rst_n,
   .serial_rx_pin, .serial_tx_out, .serial_tx_oe_n, .tx_irq, .rx_irq, .collision_irq);

// ==== usm_card_model.sv ====
`timescale 1ns/1ps
// far node on the open-drain line; the pull-up makes idle high
module usm_card_model
#(
   parameter int BIT_CYC = 32
)
(
   input wire logic clock,
   input wire logic dev_out,
   input wire logic dev_oe_n,
   output logic line
);
   logic drive_low = 1'b0;
   assign line = (dev_oe_n | dev_out) & ~drive_low;
   task automatic send(input logic [7:0] d, input logic inv, input logic bad);
      logic [10:0] f;
      for (int i = 0; i < 8; i++)
         f[i + 1] = inv ? ~d[7 - i] : d[i];
      f[0] = 1'b0;
      f[9] = bad ^ inv ^ (^d);
      f[10] = 1'b1;
      for (int i = 0; i < 11; i++)
      begin
         drive_low <= ~f[i];
         repeat (BIT_CYC) @(posedge clock);
      end
   endtask : send
   task automatic grab(output logic [10:0] f);
      int n;
      n = 0;
      while (line !== 1'b0 && n < 2000)
      begin
         @(posedge clock);
         n++;
      end
      repeat (BIT_CYC / 2) @(posedge clock);
      for (int i = 0; i < 11; i++)
      begin
         f[i] = line;
         if (i < 10) repeat (BIT_CYC) @(posedge clock);
      end
   endtask : grab
endmodule : usm_card_model

// ==== usm_channel_tb.sv ====
`timescale 1ns/1ps
module usm_channel_tb;
   localparam int BIT_CYC = 32;
   logic clock = 1'b0;
   logic rst_n = 1'b0;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic [3:0] addr = 4'h0;
   logic [15:0] wdata = 16'h0000;
   logic [15:0] rdata, d;
   logic [10:0] f;
   logic serial_rx_pin, serial_tx_out, serial_tx_oe_n, tx_irq, rx_irq, collision_irq;
   int n_mismatch = 0;
   int num_checks = 0;
   logic ext_clk = 1'b0;
   always #5 clock = ~clock;
   // external bit clock: one rising edge every two cycles
   always @(posedge clock) ext_clk <= ~ext_clk;
   usm_channel i_usm_channel (.clock, .rst_n, .addr, .wdata, .wr, .rd, .rdata, .serial_rx_pin,
      .serial_ext_clock_pin(ext_clk), .serial_tx_out, .serial_tx_oe_n, .tx_irq, .rx_irq,
      .collision_irq);
   usm_card_model #(.BIT_CYC(BIT_CYC)) i_usm_card_model (.clock(clock),
      .dev_out(serial_tx_out), .dev_oe_n(serial_tx_oe_n), .line(serial_rx_pin));
   task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
      num_checks++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("unexpected %s: expected %h, seen %h", what, exp, seen);
      end
   endtask : chk
   task automatic acc(input logic w, input logic [3:0] a, input logic [15:0] v,
      output logic [15:0] q);
      addr <= a;
      wdata <= v;
      wr <= w;
      rd <= ~w;
      @(posedge clock);
      wr <= 1'b0;
      rd <= 1'b0;
      @(posedge clock);
      q = rdata;
   endtask : acc
   task automatic wait_irq(input logic [2:0] sel, input int lim);
      int n;
      n = 0;
      while (({collision_irq, rx_irq, tx_irq} & sel) == 3'h0 && n < lim)
      begin
         @(posedge clock);
         n++;
      end
      chk("irq", {13'h0, {collision_irq, rx_irq, tx_irq} & sel}, {13'h0, sel});
   endtask : wait_irq
   task automatic give_verdict();
      $display("checks %0d, mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : give_verdict
   initial
   begin
      repeat (30000) @(posedge clock);
      n_mismatch++;
      give_verdict();
   end
   initial
   begin
      repeat (4) @(posedge clock);
      rst_n <= 1'b1;
      @(posedge clock);
      acc(1'b0, 4'h5, 16'h0000, d);
      chk("ctrl1 reset", d, {8'h00, usm_pkg::RESET_CTRL1});
      acc(1'b0, 4'h9, 16'h0000, d);
      chk("unmapped", d, 16'h0000);
      // divisor 1 at /1: two cycles per tick, 32 per bit
      acc(1'b1, 4'h2, 16'h0001, d);
      acc(1'b1, 4'h3, {13'h0, usm_pkg::MODE_SMART_CARD}, d);
      acc(1'b1, 4'h5, 16'h0094, d);
      for (int k = 0; k < 3; k++)
      begin
         acc(1'b1, 4'h4, (k == 1) ? 16'h0040 : 16'h0000, d);
         fork
            i_usm_card_model.send(8'ha5 ^ k[7:0], k == 1, k == 2);
            wait_irq(3'h2, 12 * BIT_CYC);
         join
         repeat (4) @(posedge clock);
         chk("error pulse", {15'h0, serial_tx_oe_n}, {15'h0, k != 2});
         acc(1'b0, 4'h5, 16'h0000, d);
         chk("rx complete", {15'h0, d[3]}, 16'h0001);
         acc(1'b0, 4'h1, 16'h0000, d);
         chk("rx buffer", d, {(k == 2) ? 4'hc : 4'h0, 4'h0, 8'ha5 ^ k[7:0]});
         @(posedge clock);
         chk("released", {15'h0, serial_tx_oe_n}, 16'h0001);
      end
      acc(1'b1, 4'h0, 16'h0096, d);
      acc(1'b1, 4'h5, 16'h0091, d);
      i_usm_card_model.grab(f);
      chk("tx frame", {5'h00, f}, {5'h00, 2'b10, 8'h96, 1'b0});
      wait_irq(3'h1, 2 * BIT_CYC);
      chk("line at tx end", {15'h0, serial_rx_pin}, 16'h0001);
      acc(1'b1, 4'h5, 16'h0000, d);
      // external clock, divisor 0: still 32 cycles per bit
      acc(1'b1, 4'h2, 16'h0000, d);
      acc(1'b1, 4'h3, 16'h0008 | {13'h0, usm_pkg::MODE_SHARED_BUS}, d);
      acc(1'b1, 4'h6, 16'h0030, d);
      acc(1'b1, 4'h0, 16'h00ff, d);
      i_usm_card_model.drive_low <= 1'b1;
      acc(1'b1, 4'h5, 16'h0001, d);
      wait_irq(3'h4, 4 * BIT_CYC);
      i_usm_card_model.drive_low <= 1'b0;
      acc(1'b0, 4'h5, 16'h0000, d);
      chk("tx enable", {15'h0, d[0]}, 16'h0000);
      acc(1'b0, 4'h7, 16'h0000, d);
      chk("collision flag", {15'h0, d[0]}, 16'h0001);
      give_verdict();
   end
endmodule : usm_channel_tb
